// File: core/scp_kw_match.sv
// Keyword collector and case-blind long/short form matcher
`timescale 1ns/100ps
`include "scp_defs.svh"

module scp_kw_match (
   input  wire logic              ref_clk,
   input  wire logic              rstN,
   input  wire logic              clr,
   input  wire logic              push,
   input  wire logic [7:0]        ch,
   output scp_pkg::scp_kw_t       kw
);

   localparam int KW_N = `SCP_KW_N;
   localparam scp_pkg::scp_kwstr_t [KW_N-1:0] LONGF = {
      scp_pkg::scp_kwstr_t'(`SCP_KW_OFF),
      scp_pkg::scp_kwstr_t'(`SCP_KW_ON),
      scp_pkg::scp_kwstr_t'(`SCP_KW_OPC),
      scp_pkg::scp_kwstr_t'(`SCP_KW_RST),
      scp_pkg::scp_kwstr_t'(`SCP_KW_IMM_L),
      scp_pkg::scp_kwstr_t'(`SCP_KW_INIT_L),
      scp_pkg::scp_kwstr_t'(`SCP_KW_LEV_L),
      scp_pkg::scp_kwstr_t'(`SCP_KW_POW_L),
      scp_pkg::scp_kwstr_t'(`SCP_KW_STAT_L),
      scp_pkg::scp_kwstr_t'(`SCP_KW_MULT_L),
      scp_pkg::scp_kwstr_t'(`SCP_KW_FREQ_L)};
   localparam scp_pkg::scp_kwstr_t [KW_N-1:0] SHORTF = {
      scp_pkg::scp_kwstr_t'(`SCP_KW_OFF),
      scp_pkg::scp_kwstr_t'(`SCP_KW_ON),
      scp_pkg::scp_kwstr_t'(`SCP_KW_OPC),
      scp_pkg::scp_kwstr_t'(`SCP_KW_RST),
      scp_pkg::scp_kwstr_t'(`SCP_KW_IMM_S),
      scp_pkg::scp_kwstr_t'(`SCP_KW_INIT_S),
      scp_pkg::scp_kwstr_t'(`SCP_KW_LEV_S),
      scp_pkg::scp_kwstr_t'(`SCP_KW_POW_S),
      scp_pkg::scp_kwstr_t'(`SCP_KW_STAT_S),
      scp_pkg::scp_kwstr_t'(`SCP_KW_MULT_S),
      scp_pkg::scp_kwstr_t'(`SCP_KW_FREQ_S)};

   function automatic logic [3:0] lenOf(input scp_pkg::scp_kwstr_t s);
      logic [3:0] n;
      n = 4'h0;
      for (int b = 0; b < `SCP_KW_CHARS; b++) begin
         if (s[b*8 +: 8] != `SCP_CH_NUL)
            n = n + `SCP_LEN_ONE;
      end
      return n;
   endfunction

   scp_pkg::scp_kwst_t  s;
   scp_pkg::scp_kwst_t  n;
   scp_pkg::scp_kwstr_t nBuf;
   scp_pkg::scp_kwstr_t mask;
   logic [3:0]          nLen;
   logic [7:0]          chU;
   logic [KW_N-1:0]     hit;

   // Folding case before storing lets one spelling serve all cases
   always_comb begin
      chU = ch;
      if (ch >= `SCP_CH_LA && ch <= `SCP_CH_LZ)
         chU = ch & ~`SCP_CASE_BIT;
      nBuf = clr ? '0 : s.buffer;
      nLen = clr ? 4'h0 : s.len;
      if (push) begin
         nBuf = {nBuf[`SCP_KW_BITS-9:0], chU};
         if (nLen != `SCP_LEN_OVF)
            nLen = nLen + `SCP_LEN_ONE;
      end
      mask = ~({`SCP_KW_BITS{1'b1}} << {nLen, 3'b000});
   end

   // Only the exact short or exact long length can hit; mixtures fail
   for (genvar i = 0; i < KW_N; i++) begin : gEntry
      localparam logic [3:0] LL = lenOf(LONGF[i]);
      localparam logic [3:0] SL = lenOf(SHORTF[i]);
      assign hit[i] =
         (nLen == LL && ((nBuf ^ LONGF[i]) & mask) == '0) ||
         (nLen == SL && ((nBuf ^ SHORTF[i]) & mask) == '0);
   end

   always_comb begin
      n = s;
      n.buffer = nBuf;
      n.len = nLen;
      n.kw = scp_pkg::KW_NONE;
      for (int i = 0; i < KW_N; i++) begin
         if (hit[i])
            n.kw = scp_pkg::scp_kw_t'(4'(i + 1));
      end
   end

   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN)
         s <= '0;
      else
         s <= n;
   end

   assign kw = s.kw;

endmodule

// File: core/scp_parser.sv
// Program message parser with command tree path tracking
// Operation
// - Send a response only after a query asked for it.
// - A keyword ending in question mark is a query, answering not setting.
// - Every programmable setting can also be read back by its query.
// - Boolean parameters accept ON/OFF or 1/0 with identical effect.
// - Each query answers in one fixed format; true reads back as 1.
// - Asterisk commands are common and ignore the current path.
// - Power-up and the reset command put the path at the root.
// - A newline terminator returns the path to the root.
// - A colon between keywords steps the path one level down.
// - A leading colon resolves the next keyword at the root.
// - Semicolon ends a command and keeps the path unchanged.
// - Whitespace between tokens ignored, not inside keywords; path kept.
// - Commas are not accepted; a comma in a parameter is a command error.
// - A parent without its implied child acts as if child sent.
// - Commands through an implied node leave the path where it was.
// - A keyword unknown at the current level raises a command error.
// - An omitted optional parameter takes its predefined default.
// - Event commands act at once, hold no state, refuse queries.
// - Keywords match case-blind, only exact short or long form.
// - Each response ends in newline sent with end-of-message flag.
`timescale 1ns/100ps
`include "scp_defs.svh"

module scp_parser (
   input  wire logic              ref_clk,
   input  wire logic              rst_b,
   input  wire scp_pkg::scp_rx_t  rx,
   output logic                   rxReady,
   input  wire logic              txReady,
   output scp_pkg::scp_tx_t       tx,
   output scp_pkg::scp_set_t      set,
   output logic                   initPulse,
   output logic                   cmdError
);

   localparam scp_pkg::scp_set_t SET_DEF = '{
      freqMult:  `SCP_MULT_DEF,
      freqState: `SCP_FST_DEF,
      powState:  `SCP_PST_DEF,
      powLevel:  `SCP_LEV_DEF};

   logic [1:0]          rstSync;
   logic                rstN;
   scp_pkg::scp_ps_t    s;
   scp_pkg::scp_ps_t    n;
   scp_pkg::scp_kw_t    kw;
   scp_pkg::scp_leaf_t  rLeaf;
   logic                rImp;
   logic                rValid;
   logic                kwClr;
   logic                kwPush;
   logic                respBusy;
   logic                take;
   logic [7:0]          ch;
   logic                isNl;
   logic                isSemi;
   logic                isEnd;
   logic                isWs;
   logic                isColon;
   logic                isComma;
   logic                isQuery;
   logic                isStar;
   logic                isLetter;
   logic                isDigit;
   logic                err;
   logic                ok;
   logic                resp;
   logic [7:0]          ansByte;
   logic                bTrue;
   logic                bFalse;
   logic                dOk;

   // Reset is released through two flops so all state leaves it together
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b)
         rstSync <= 2'b00;
      else
         rstSync <= {rstSync[0], 1'b1};
   end
   assign rstN = rstSync[1];

   scp_kw_match uMatch (
      .ref_clk (ref_clk),
      .rstN    (rstN),
      .clr     (kwClr),
      .push    (kwPush),
      .ch      (ch),
      .kw      (kw)
   );

   scp_resp uResp (
      .ref_clk (ref_clk),
      .rstN    (rstN),
      .go      (s.respGo),
      .goByte  (s.respByte),
      .txReady (txReady),
      .tx      (tx),
      .busy    (respBusy)
   );

   assign take = rx.valid && s.rdy;
   assign ch = rx.data;
   assign isNl = ch == `SCP_CH_NL;
   assign isSemi = ch == `SCP_CH_SEMI;
   assign isEnd = isNl || isSemi;
   assign isWs = ch == `SCP_CH_SP || ch == `SCP_CH_TAB;
   assign isColon = ch == `SCP_CH_COLON;
   assign isComma = ch == `SCP_CH_COMMA;
   assign isQuery = ch == `SCP_CH_QUERY;
   assign isStar = ch == `SCP_CH_STAR;
   assign isLetter = (ch >= `SCP_CH_UA && ch <= `SCP_CH_UZ) ||
                     (ch >= `SCP_CH_LA && ch <= `SCP_CH_LZ);
   assign isDigit = ch >= `SCP_CH_ZERO && ch <= `SCP_CH_NINE;

   // Resolve the finished keyword against the level it stands at
   always_comb begin
      rLeaf = scp_pkg::LF_NONE;
      rImp = 1'b0;
      if (!s.stepped && kw == scp_pkg::KW_RST)
         rLeaf = scp_pkg::LF_RST;
      else if (!s.stepped && kw == scp_pkg::KW_OPC)
         rLeaf = scp_pkg::LF_OPC;
      else begin
         case (s.head)
            scp_pkg::ND_ROOT: begin
               rImp = 1'b1;
               case (kw)
                  scp_pkg::KW_FREQ: rLeaf = scp_pkg::LF_FMULT;
                  scp_pkg::KW_POW:  rLeaf = scp_pkg::LF_PSTAT;
                  scp_pkg::KW_INIT: rLeaf = scp_pkg::LF_IIMM;
                  default:          rLeaf = scp_pkg::LF_NONE;
               endcase
            end
            scp_pkg::ND_FREQ: begin
               case (kw)
                  scp_pkg::KW_MULT: rLeaf = scp_pkg::LF_FMULT;
                  scp_pkg::KW_STAT: rLeaf = scp_pkg::LF_FSTAT;
                  default:          rLeaf = scp_pkg::LF_NONE;
               endcase
            end
            scp_pkg::ND_POW: begin
               case (kw)
                  scp_pkg::KW_STAT: rLeaf = scp_pkg::LF_PSTAT;
                  scp_pkg::KW_LEV:  rLeaf = scp_pkg::LF_PLEV;
                  default:          rLeaf = scp_pkg::LF_NONE;
               endcase
            end
            scp_pkg::ND_INIT: begin
               if (kw == scp_pkg::KW_IMM)
                  rLeaf = scp_pkg::LF_IIMM;
            end
            default: rLeaf = scp_pkg::LF_NONE;
         endcase
      end
      rValid = rLeaf != scp_pkg::LF_NONE;
   end

   // Parameter decoding; kw here holds the parameter token's match
   always_comb begin
      bTrue = s.pSeen && (kw == scp_pkg::KW_ON ||
              (s.pLen == `SCP_LEN_ONE && s.pChar == `SCP_CH_ONE));
      bFalse = s.pSeen && (kw == scp_pkg::KW_OFF ||
               (s.pLen == `SCP_LEN_ONE && s.pChar == `SCP_CH_ZERO));
      dOk = s.pSeen && s.pLen == `SCP_LEN_ONE &&
            s.pChar >= `SCP_CH_ZERO && s.pChar <= `SCP_CH_NINE;
   end

   always_comb begin
      n = s;
      n.cmdErr = 1'b0;
      n.initPulse = 1'b0;
      n.respGo = 1'b0;
      kwClr = 1'b0;
      kwPush = 1'b0;
      err = 1'b0;
      ok = 1'b1;
      resp = 1'b0;
      ansByte = `SCP_CH_ZERO;
      if (take)
         n.termNl = isNl;
      case (s.st)
         scp_pkg::ST_IDLE: begin
            n.stepped = 1'b0;
            n.query = 1'b0;
            n.gap = 1'b0;
            n.pSeen = 1'b0;
            n.pLen = 4'h0;
            n.head = s.path;
            if (take) begin
               if (isNl)
                  n.path = scp_pkg::ND_ROOT;
               else if (isColon) begin
                  n.path = scp_pkg::ND_ROOT;
                  n.head = scp_pkg::ND_ROOT;
                  kwClr = 1'b1;
                  n.st = scp_pkg::ST_HDR;
               end else if (isLetter || isStar) begin
                  kwClr = 1'b1;
                  kwPush = 1'b1;
                  n.st = scp_pkg::ST_HDR;
               end else if (!isWs && !isSemi)
                  err = 1'b1;
            end
         end
         scp_pkg::ST_HDR: begin
            if (take) begin
               n.leaf = rLeaf;
               n.implied = rImp;
               if (isLetter || isDigit || isStar)
                  kwPush = 1'b1;
               else if (isColon) begin
                  kwClr = 1'b1;
                  n.stepped = 1'b1;
                  if (s.head != scp_pkg::ND_ROOT)
                     err = 1'b1;
                  else if (kw == scp_pkg::KW_FREQ)
                     n.head = scp_pkg::ND_FREQ;
                  else if (kw == scp_pkg::KW_POW)
                     n.head = scp_pkg::ND_POW;
                  else if (kw == scp_pkg::KW_INIT)
                     n.head = scp_pkg::ND_INIT;
                  else
                     err = 1'b1;
               end else if (!rValid)
                  err = 1'b1;
               else if (isQuery) begin
                  n.query = 1'b1;
                  n.st = scp_pkg::ST_GAP;
               end else if (isWs) begin
                  n.gap = 1'b1;
                  n.st = scp_pkg::ST_GAP;
               end else if (isEnd)
                  n.st = scp_pkg::ST_EXEC;
               else
                  err = 1'b1;
            end
         end
         scp_pkg::ST_GAP: begin
            if (take) begin
               if (isWs)
                  n.gap = 1'b1;
               else if (isEnd)
                  n.st = scp_pkg::ST_EXEC;
               else if ((isLetter || isDigit) && s.gap && !s.pSeen &&
                        !s.query) begin
                  n.pSeen = 1'b1;
                  n.pLen = `SCP_LEN_ONE;
                  n.pChar = ch;
                  kwClr = 1'b1;
                  kwPush = 1'b1;
                  n.st = scp_pkg::ST_PARM;
               end else
                  err = 1'b1;
            end
         end
         scp_pkg::ST_PARM: begin
            if (take) begin
               if (isLetter || isDigit) begin
                  kwPush = 1'b1;
                  if (s.pLen != `SCP_LEN_OVF)
                     n.pLen = s.pLen + `SCP_LEN_ONE;
               end else if (isWs)
                  n.st = scp_pkg::ST_GAP;
               else if (isEnd)
                  n.st = scp_pkg::ST_EXEC;
               else
                  err = 1'b1;
            end
         end
         scp_pkg::ST_EXEC: begin
            if (s.query) begin
               if (s.pSeen)
                  ok = 1'b0;
               case (s.leaf)
                  scp_pkg::LF_FMULT:
                     ansByte = `SCP_CH_ZERO | {4'h0, s.set.freqMult};
                  scp_pkg::LF_FSTAT:
                     ansByte = s.set.freqState ? `SCP_CH_ONE
                                               : `SCP_CH_ZERO;
                  scp_pkg::LF_PSTAT:
                     ansByte = s.set.powState ? `SCP_CH_ONE
                                              : `SCP_CH_ZERO;
                  scp_pkg::LF_PLEV:
                     ansByte = `SCP_CH_ZERO | {4'h0, s.set.powLevel};
                  scp_pkg::LF_OPC:
                     ansByte = `SCP_OPC_ANS;
                  default: ok = 1'b0;
               endcase
               resp = ok;
            end else begin
               case (s.leaf)
                  scp_pkg::LF_FMULT: begin
                     if (dOk)
                        n.set.freqMult = s.pChar[3:0];
                     else
                        ok = 1'b0;
                  end
                  scp_pkg::LF_FSTAT: begin
                     if (bTrue || bFalse)
                        n.set.freqState = bTrue;
                     else
                        ok = 1'b0;
                  end
                  scp_pkg::LF_PSTAT: begin
                     if (bTrue || bFalse)
                        n.set.powState = bTrue;
                     else
                        ok = 1'b0;
                  end
                  scp_pkg::LF_PLEV: begin
                     if (!s.pSeen)
                        n.set.powLevel = `SCP_LEV_OPT;
                     else if (dOk)
                        n.set.powLevel = s.pChar[3:0];
                     else
                        ok = 1'b0;
                  end
                  scp_pkg::LF_IIMM: begin
                     ok = !s.pSeen;
                     n.initPulse = !s.pSeen;
                  end
                  scp_pkg::LF_RST: begin
                     ok = !s.pSeen;
                     if (!s.pSeen) begin
                        n.set = SET_DEF;
                        n.path = scp_pkg::ND_ROOT;
                     end
                  end
                  scp_pkg::LF_OPC: ok = !s.pSeen;
                  default: ok = 1'b0;
               endcase
            end
            // Implied commands and *OPC keep the path; *RST has set the root above
            if (ok && !s.implied && s.leaf != scp_pkg::LF_RST &&
                s.leaf != scp_pkg::LF_OPC)
               n.path = s.head;
            if (s.termNl)
               n.path = scp_pkg::ND_ROOT;
            n.cmdErr = !ok;
            n.respGo = resp;
            n.respByte = ansByte;
            n.st = resp ? scp_pkg::ST_RESP : scp_pkg::ST_IDLE;
         end
         scp_pkg::ST_RESP: begin
            // Input stays stalled so a second query cannot overtake
            if (!respBusy && !s.respGo)
               n.st = scp_pkg::ST_IDLE;
         end
         scp_pkg::ST_SKIP: begin
            if (take && isNl) begin
               n.path = scp_pkg::ND_ROOT;
               n.st = scp_pkg::ST_IDLE;
            end else if (take && isSemi)
               n.st = scp_pkg::ST_IDLE;
         end
         default: n.st = scp_pkg::ST_IDLE;
      endcase
      if (err) begin
         n.cmdErr = 1'b1;
         if (isNl) begin
            n.path = scp_pkg::ND_ROOT;
            n.st = scp_pkg::ST_IDLE;
         end else if (isSemi)
            n.st = scp_pkg::ST_IDLE;
         else
            n.st = scp_pkg::ST_SKIP;
      end
      n.rdy = n.st != scp_pkg::ST_EXEC && n.st != scp_pkg::ST_RESP;
   end

   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) begin
         s <= '0;
         s.rdy <= 1'b1;
         s.set <= SET_DEF;
      end else
         s <= n;
   end

   assign rxReady = s.rdy;
   assign set = s.set;
   assign initPulse = s.initPulse;
   assign cmdError = s.cmdErr;

endmodule

// File: core/scp_resp.sv
// Response sender: one data byte then newline marked end of message
`timescale 1ns/100ps
`include "scp_defs.svh"

module scp_resp (
   input  wire logic              ref_clk,
   input  wire logic              rstN,
   input  wire logic              go,
   input  wire logic [7:0]        goByte,
   input  wire logic              txReady,
   output scp_pkg::scp_tx_t       tx,
   output logic                   busy
);

   scp_pkg::scp_tx_t s;
   scp_pkg::scp_tx_t n;

   always_comb begin
      n = s;
      if (s.valid && txReady) begin
         if (s.last) begin
            n.valid = 1'b0;
            n.last = 1'b0;
         end else begin
            n.data = `SCP_CH_NL;
            n.last = 1'b1;
         end
      end
      if (go && !s.valid) begin
         n.valid = 1'b1;
         n.last = 1'b0;
         n.data = goByte;
      end
   end

   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN)
         s <= '0;
      else
         s <= n;
   end

   assign tx = s;
   assign busy = s.valid;

endmodule

// File: inc/scp_defs.svh
// Character codes, defaults and keyword spellings of the command parser
`ifndef SCP_DEFS_SVH
`define SCP_DEFS_SVH

`define SCP_CH_NUL    8'h00
`define SCP_CH_TAB    8'h09
`define SCP_CH_NL     8'h0a
`define SCP_CH_SP     8'h20
`define SCP_CH_STAR   8'h2a
`define SCP_CH_COMMA  8'h2c
`define SCP_CH_ZERO   8'h30
`define SCP_CH_ONE    8'h31
`define SCP_CH_NINE   8'h39
`define SCP_CH_COLON  8'h3a
`define SCP_CH_SEMI   8'h3b
`define SCP_CH_QUERY  8'h3f
`define SCP_CH_UA     8'h41
`define SCP_CH_UZ     8'h5a
`define SCP_CH_LA     8'h61
`define SCP_CH_LZ     8'h7a
`define SCP_CASE_BIT  8'h20

`define SCP_KW_CHARS  12
`define SCP_KW_BITS   96
`define SCP_KW_N      11
`define SCP_LEN_OVF   4'hd
`define SCP_LEN_ONE   4'h1

`define SCP_MULT_DEF  4'h1
`define SCP_FST_DEF   1'b0
`define SCP_PST_DEF   1'b0
`define SCP_LEV_DEF   4'h0
`define SCP_LEV_OPT   4'h0
`define SCP_OPC_ANS   8'h31

`define SCP_KW_FREQ_L "FREQUENCY"
`define SCP_KW_FREQ_S "FREQ"
`define SCP_KW_MULT_L "MULTIPLIER"
`define SCP_KW_MULT_S "MULT"
`define SCP_KW_STAT_L "STATE"
`define SCP_KW_STAT_S "STAT"
`define SCP_KW_POW_L  "POWER"
`define SCP_KW_POW_S  "POW"
`define SCP_KW_LEV_L  "LEVEL"
`define SCP_KW_LEV_S  "LEV"
`define SCP_KW_INIT_L "INITIATE"
`define SCP_KW_INIT_S "INIT"
`define SCP_KW_IMM_L  "IMMEDIATE"
`define SCP_KW_IMM_S  "IMM"
`define SCP_KW_RST    "*RST"
`define SCP_KW_OPC    "*OPC"
`define SCP_KW_ON     "ON"
`define SCP_KW_OFF    "OFF"

`endif

// File: inc/scp_pkg.sv
// Types shared by the command parser modules
`include "scp_defs.svh"

package scp_pkg;

   typedef logic [`SCP_KW_BITS-1:0] scp_kwstr_t;

   typedef enum logic [1:0] {
      ND_ROOT, ND_FREQ, ND_POW, ND_INIT
   } scp_node_t;

   typedef enum logic [3:0] {
      KW_NONE, KW_FREQ, KW_MULT, KW_STAT, KW_POW, KW_LEV,
      KW_INIT, KW_IMM, KW_RST, KW_OPC, KW_ON, KW_OFF
   } scp_kw_t;

   typedef enum logic [2:0] {
      LF_NONE, LF_FMULT, LF_FSTAT, LF_PSTAT, LF_PLEV, LF_IIMM,
      LF_RST, LF_OPC
   } scp_leaf_t;

   typedef enum logic [2:0] {
      ST_IDLE, ST_HDR, ST_GAP, ST_PARM, ST_EXEC, ST_RESP, ST_SKIP
   } scp_state_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } scp_rx_t;

   typedef struct packed {
      logic       valid;
      logic       last;
      logic [7:0] data;
   } scp_tx_t;

   typedef struct packed {
      logic [3:0] freqMult;
      logic       freqState;
      logic       powState;
      logic [3:0] powLevel;
   } scp_set_t;

   typedef struct packed {
      scp_kwstr_t buffer;
      logic [3:0] len;
      scp_kw_t    kw;
   } scp_kwst_t;

   typedef struct packed {
      scp_state_t st;
      logic       rdy;
      scp_node_t  path;
      scp_node_t  head;
      logic       stepped;
      logic       implied;
      scp_leaf_t  leaf;
      logic       query;
      logic       gap;
      logic       pSeen;
      logic [3:0] pLen;
      logic [7:0] pChar;
      logic       termNl;
      scp_set_t   set;
      logic       initPulse;
      logic       cmdErr;
      logic       respGo;
      logic [7:0] respByte;
   } scp_ps_t;

endpackage

// File: sim/scp_host_model.sv
// Controller model: sends program messages, collects response bytes
`timescale 1ns/100ps
module scp_host_model (
   input  wire logic             ref_clk,
   input  wire logic             rxReady,
   input  wire scp_pkg::scp_tx_t tx,
   input  wire logic             slow,
   output scp_pkg::scp_rx_t      rx,
   output logic                  txReady
);
   logic [8:0] got[$];
   initial begin
      rx = '0;
      txReady = 1'b1;
   end
   // A slow controller takes a byte only every other cycle
   always @(negedge ref_clk) begin
      txReady <= !slow || !txReady;
   end
   always @(posedge ref_clk) begin
      if (tx.valid && txReady) begin
         got.push_back({tx.last, tx.data});
      end
   end
   // Messages are sent byte by byte exactly as the caller wrote them
   task automatic send(input string s);
      for (int i = 0; i < s.len(); i++) begin
         @(negedge ref_clk);
         rx.valid = 1'b1;
         rx.data = s[i];
         do @(posedge ref_clk); while (rxReady !== 1'b1);
      end
      @(negedge ref_clk);
      rx.valid = 1'b0;
      rx.data = ~rx.data;
   endtask
endmodule

// File: sim/scp_parser_props.sv
// Checker of the parser stream and response timing
`timescale 1ns/100ps
module scp_parser_props (
   input wire logic              ref_clk,
   input wire logic              rst_b,
   input wire scp_pkg::scp_rx_t  rx,
   input wire logic              rxReady,
   input wire logic              txReady,
   input wire scp_pkg::scp_tx_t  tx,
   input wire scp_pkg::scp_set_t set,
   input wire logic              initPulse,
   input wire logic              cmdError
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   AST_TX_QUIET: assert property (tx.valid |-> !rxReady)
      else $error("response while input open");
   AST_SET_EXEC: assert property (!$stable(set) |-> !$past(rxReady))
      else $error("setting moved outside execute");
   AST_PAIR: assert property (tx.valid && !tx.last && txReady |=>
      tx.valid && tx.last && tx.data == 8'h0a) else $error("no newline");
   AST_HOLD: assert property (tx.valid && !txReady |=>
      tx.valid && $stable(tx.data) && $stable(tx.last)) else $error("drop");
   AST_DIGIT: assert property (tx.valid && !tx.last |->
      tx.data inside {[8'h30:8'h39]}) else $error("bad value byte");
   AST_END: assert property (tx.valid && tx.last && txReady |=>
      !tx.valid ##1 rxReady) else $error("input not reopened");
   AST_INIT: assert property (initPulse |->
      !$past(rxReady) ##1 !initPulse) else $error("bad event pulse");
   AST_TAKE: assert property (rx.valid && rxReady &&
      !(rx.data inside {8'h3b, 8'h0a}) |=> rxReady) else $error("stall");
endmodule
bind scp_parser scp_parser_props u_props (.ref_clk(ref_clk), .rst_b(rst_b),
   .rx(rx), .rxReady(rxReady), .txReady(txReady), .tx(tx), .set(set),
   .initPulse(initPulse), .cmdError(cmdError));

// File: sim/scp_parser_tb.sv
// Self-checking bench of the command parser
`timescale 1ns/100ps
module scp_parser_tb;
   typedef struct {string m; logic [9:0] s; string r; int e; int p;} scp_row_t;
   logic              ref_clk = 1'b0;
   logic              rst_b = 1'b0;
   logic              slow = 1'b0;
   scp_pkg::scp_rx_t  rx;
   logic              rxReady;
   logic              txReady;
   scp_pkg::scp_tx_t  tx;
   scp_pkg::scp_set_t set;
   logic              initPulse;
   logic              cmdError;
   int                mismatches = 0;
   int                checks = 0;
   int                errs = 0;
   int                pulses = 0;
   int                cyc = 0;
   scp_row_t          rows[10] = '{
      '{"FREQ:STAT ON\n", 10'h060, "", 0, 0},
      '{"freq:stat off;stat?\n", 10'h040, "0", 0, 0},
      '{"POW 1;LEV 7\n", 10'h050, "", 1, 0},
      '{"POWER:LEVEL 5;:POW:STAT?;LEV?\n", 10'h055, "15", 0, 0},
      '{"POW:LEV\n", 10'h050, "", 0, 0},
      '{"FREQUENCY:MULTIPLIER 9;MULT?\n", 10'h250, "9", 0, 0},
      '{"FREQ 3; FREQ:MUL 4\n", 10'h0d0, "", 1, 0},
      '{"INIT:IMM?\nINIT\nFR EQ 1\n", 10'h0d0, "", 2, 1},
      '{"FREQ:MULT 2,3\nFREQ:STAT 0;*OPC?;STAT 1\n", 10'h0f0, "1", 1, 0},
      '{"FREQ:MULT 2\n\tSTAT 1\n", 10'h0b0, "", 1, 0}
   }; // and row 9
   scp_parser DUT (.ref_clk(ref_clk), .rst_b(rst_b), .rx(rx),
      .rxReady(rxReady), .txReady(txReady), .tx(tx), .set(set),
      .initPulse(initPulse), .cmdError(cmdError));
   scp_host_model host (.ref_clk(ref_clk), .rxReady(rxReady), .tx(tx),
      .slow(slow), .rx(rx), .txReady(txReady));
   initial forever #25 ref_clk = ~ref_clk;
   task automatic end_of_test;
      if (mismatches == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] a, input logic [15:0] b);
      checks++;
      if (a !== b) begin
         mismatches++;
         $display("ERROR t=%0t got=%h exp=%h", $time, a, b);
      end
   endtask
   // Response bytes alternate value and newline-with-end flag
   task automatic run(string m, logic [9:0] s, string r, int e, int p);
      int e0 = errs;
      int p0 = pulses;
      host.got.delete();
      host.send(m);
      for (int i = 0; i < 40 && rxReady !== 1'b1; i++) @(negedge ref_clk);
      repeat (2) @(negedge ref_clk);
      if (s !== 10'h3ff) chk(set, s);
      chk(errs - e0, e);
      chk(pulses - p0, p);
      chk(host.got.size(), 2 * r.len());
      foreach (host.got[i])
         chk(host.got[i], i % 2 ? 9'h10a : r[i / 2]);
   endtask
   always @(posedge ref_clk) begin
      errs += (cmdError === 1'b1);
      pulses += (initPulse === 1'b1);
      cyc++;
      if (cyc == 4000) begin
         mismatches++;
         end_of_test();
      end
   end
   initial begin
      repeat (4) @(negedge ref_clk);
      rst_b = 1'b1;
      repeat (3) @(negedge ref_clk);
      foreach (rows[i])
         run(rows[i].m, rows[i].s, rows[i].r, rows[i].e, rows[i].p);
      slow = 1'b1;
      run("FREQ:MULT 4;*RST;MULT 6;*OPC?\n", 10'h040, "1", 1, 0);
      rst_b = 1'b0;
      @(negedge ref_clk);
      chk(set, 10'h040);
      rst_b = 1'b1;
      repeat (3) @(negedge ref_clk);
      run("STAT 1\n", 10'h040, "", 1, 0);
      end_of_test();
   end
endmodule
